// *** sct_params.svh ***
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
// Function
// - hard reset pin held low at least 10 us starts the internal reset; here any low level on RESET_N resets at once, with no minimum width
// - during hard reset: pull-downs on, other outputs high-z, inputs isolated
// - reset pin release runs start-up and restores every register default
// - bit 8 of system setup register does soft reset without low power
// - standby entered at once on switch-mode standby; outputs keep levels
// - standby loses registers except pad setup, pad output, temperature threshold
// - standby left on enabled wake: timer, RF level, reset pin, supply loss
// - any host command during standby triggers the start-up sequence
// - start-up end raises start-up-done flag; host commands accepted from then
// - after power-up the device defaults to card emulation mode
// - temperature threshold register selects 85, 115, 125 or 135 C
// - over-temperature switches off RF field and sets its status flag
// - over-temperature detection always active; only pin routing is enabled
// - three 20-bit timers clocked from the 13.56 MHz system rate
// - prescaler picks eight tick rates halving from 6.78 MHz to 53 kHz
// - timer start events: now, RF on/off, receive or transmit start/end
// - timers reload their counter on expiry when reload is enabled, else stop; expiry sets a flag and an interrupt
// - third timer hidden from host while card authentication runs
// - with disturbance handling on, second timer restarts on each disturbance
// - per-source pin enables; flags always set; three sources non-maskable
// - flags cleared by clear register write or status read, per config
// - interrupt pin active while any enabled flag set; polarity configurable
// - leaving standby resets internal registers to defaults

// ****************************************
// register offsets
// ****************************************
`define SCT_OFS_SYSTEM_SETUP 8'h00
`define SCT_OFS_IRQ_ENABLE 8'h01
`define SCT_OFS_IRQ_STATUS 8'h02
`define SCT_OFS_IRQ_CLEAR 8'h03
`define SCT_OFS_PAD_SETUP 8'h05
`define SCT_OFS_PAD_OUTPUT 8'h07
`define SCT_OFS_TIMER_RELOAD 8'h10
`define SCT_OFS_TIMER_CONFIG 8'h13
`define SCT_OFS_TIMER_VALUE 8'h16
`define SCT_OFS_OVERTEMP 8'h25
`define SCT_OFS_DISTURB 8'h28
`define SCT_OFS_WAKE_CONFIG 8'h30

// ****************************************
// fields and reset values
// ****************************************
`define SCT_BIT_RF_ENABLE 0
`define SCT_BIT_CARD_MODE 1
`define SCT_BIT_SOFT_RESET 8
`define SCT_BIT_DISTURB_ON 0
`define SCT_SYSTEM_SETUP_RST 32'h0000_0002
`define SCT_IRQ_ENABLE_RST 8'h00
`define SCT_NONMASK 8'he0
`define SCT_IRQ_IDLE 0
`define SCT_IRQ_TIMER0 1
`define SCT_IRQ_OVERTEMP 4
`define SCT_IRQ_CARD 5
`define SCT_IRQ_GEN_ERR 6
`define SCT_IRQ_HV_ERR 7

// ****************************************
// command codes
// ****************************************
`define SCT_CMD_WRITE 8'h00
`define SCT_CMD_WRITE_OR 8'h01
`define SCT_CMD_WRITE_AND 8'h02
`define SCT_CMD_READ 8'h04
`define SCT_CMD_SWITCH_MODE 8'h0b
`define SCT_MODE_STANDBY 32'h0000_0000

// ****************************************
// timing
// ****************************************
`define SCT_CLK_KHZ 100000
`define SCT_SYS_KHZ 13560
`define SCT_CLK_PERIOD_NS 10
`define SCT_HARD_RESET_MIN_NS 10000
`define SCT_HARD_RESET_CYC ((`SCT_HARD_RESET_MIN_NS + `SCT_CLK_PERIOD_NS - 1) / `SCT_CLK_PERIOD_NS)
`define SCT_STARTUP_CYC 64
`endif

// *** sct_pkg.sv ***
package sct_pkg;
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] addr;
		logic [31:0] data;
	} sct_cmd_t;

	typedef struct packed {
		logic reload_en;
		logic [2:0] start_sel;
		logic [2:0] prescale;
	} sct_tcfg_t;

	typedef enum logic [1:0] {
		ST_STARTUP = 2'b00,
		ST_RUN = 2'b01,
		ST_STANDBY = 2'b10
	} sct_state_t;

	typedef enum logic [2:0] {
		SEL_NOW = 3'b000,
		SEL_RF_ON = 3'b001,
		SEL_RF_OFF = 3'b010,
		SEL_RX_START = 3'b011,
		SEL_RX_END = 3'b100,
		SEL_TX_START = 3'b101,
		SEL_TX_END = 3'b110
	} sct_start_t;
endpackage : sct_pkg

// *** sct_top.sv ***
`timescale 1ns/1ns
`include "sct_params.svh"
module sct_top #(
	parameter int STARTUP_CYC = `SCT_STARTUP_CYC
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CMD_VALID,
	input wire sct_pkg::sct_cmd_t CMD,
	output logic [31:0] RD_DATA,
	output logic RD_VALID,
	input wire logic RF_FIELD,
	input wire logic [3:0] TEMP_ABOVE,
	input wire logic RF_LEVEL_DET,
	input wire logic PVDD_LOST,
	input wire logic RX_START,
	input wire logic RX_END,
	input wire logic TX_START,
	input wire logic TX_END,
	input wire logic EMD_EVENT,
	input wire logic AUTH_ACTIVE,
	input wire logic CARD_DETECT,
	input wire logic GENERAL_ERROR,
	input wire logic HV_FAULT,
	input wire logic CLEAR_ON_READ,
	input wire logic IRQ_ACTIVE_HIGH,
	output logic IRQ_O,
	output logic IRQ_OE,
	output logic PULL_DOWN_EN,
	output logic OUT_HIZ,
	output logic INPUT_ISOLATE,
	output logic LOW_POWER,
	output logic READY,
	output logic STANDBY,
	output logic RF_ON,
	output logic CARD_MODE,
	output logic [31:0] PAD_SETUP,
	output logic [31:0] PAD_OUT
);
	import sct_pkg::*;

	localparam logic [16:0] SYS_STEP = 17'(`SCT_SYS_KHZ);
	localparam logic [16:0] SYS_MOD = 17'(`SCT_CLK_KHZ);

	// ****************************************
	// reset release and pin synchronisers
	// ****************************************
	logic [1:0] rst_sync;
	logic rst_n;
	logic in_reset;
	logic [6:0] pin_s1, pin_s2, pin_s3, pin_q;
	logic rf_field, rf_level, pvdd_lost;
	logic [3:0] temp_above;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// pads isolated and pulled down until the reset has left
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			in_reset <= 1'b1;
			IRQ_OE <= 1'b0;
		end else begin
			in_reset <= 1'b0;
			IRQ_OE <= 1'b1;
		end
	end
	assign PULL_DOWN_EN = in_reset;
	assign OUT_HIZ = in_reset;
	assign INPUT_ISOLATE = in_reset;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= 7'h00;
			pin_s2 <= 7'h00;
			pin_s3 <= 7'h00;
			pin_q <= 7'h00;
		end else begin
			pin_s1 <= {PVDD_LOST, RF_LEVEL_DET, TEMP_ABOVE, RF_FIELD};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			// follow the pin once the second and third stages agree, else hold
			pin_q <= (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_q & (pin_s2 ^ pin_s3));
		end
	end
	assign rf_field = pin_q[0];
	assign temp_above = pin_q[4:1];
	assign rf_level = pin_q[5];
	assign pvdd_lost = pin_q[6];

	// ****************************************
	// mode sequencing
	// ****************************************
	sct_state_t state;
	logic [$clog2(STARTUP_CYC+1)-1:0] su_cnt;
	logic soft_rst, wake, startup_done;
	logic [2:0] wake_en;
	logic [31:0] wake_cfg;
	logic cmd_ok, cmd_wr, cmd_rd, cmd_standby;
	logic [2:0] t_expire;
	logic [31:0] rd_mux, wval;

	assign cmd_ok = CMD_VALID && (state == ST_RUN);
	assign cmd_wr = cmd_ok && (CMD.code == `SCT_CMD_WRITE || CMD.code == `SCT_CMD_WRITE_OR ||
		CMD.code == `SCT_CMD_WRITE_AND);
	assign cmd_rd = cmd_ok && (CMD.code == `SCT_CMD_READ);
	assign cmd_standby = cmd_ok && (CMD.code == `SCT_CMD_SWITCH_MODE) &&
		(CMD.data == `SCT_MODE_STANDBY);
	assign wake = (state == ST_STANDBY) && (CMD_VALID || (wake_en[0] && t_expire[0]) ||
		(wake_en[1] && rf_level) || (wake_en[2] && pvdd_lost));

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_STARTUP;
			su_cnt <= '0;
			startup_done <= 1'b0;
			wake_en <= 3'b000;
		end else begin
			startup_done <= 1'b0;
			case (state)
				ST_STARTUP: begin
					if (su_cnt == ($bits(su_cnt))'(STARTUP_CYC - 1)) begin
						state <= ST_RUN;
						su_cnt <= '0;
						startup_done <= 1'b1;
					end else begin
						su_cnt <= su_cnt + 1'b1;
					end
				end
				ST_RUN: begin
					if (soft_rst) begin
						state <= ST_STARTUP;
					end else if (cmd_standby) begin
						state <= ST_STANDBY;
						wake_en <= wake_cfg[2:0];
					end
				end
				ST_STANDBY: begin
					if (wake) begin
						state <= ST_STARTUP;
					end
				end
				default: state <= ST_STARTUP;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			READY <= 1'b0;
			STANDBY <= 1'b0;
			LOW_POWER <= 1'b1;
		end else begin
			READY <= (state == ST_RUN) && !soft_rst && !cmd_standby;
			STANDBY <= (state == ST_STANDBY) ? !wake : cmd_standby;
			LOW_POWER <= (state == ST_STANDBY) ? !wake : cmd_standby;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [31:0] sys_setup, pad_setup_reg, pad_output_reg, overtemp_threshold_reg;
	logic [31:0] disturbance_ctrl_reg;
	logic [7:0] irq_enable, irq_status, irq_set, irq_clr;
	logic wipe;
	logic overtemp_event;
	logic [19:0] t_value [3];
	logic [19:0] t_reload [3];
	sct_tcfg_t t_cfg [3];

	assign wipe = soft_rst || wake;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (CMD.addr)
			`SCT_OFS_SYSTEM_SETUP: rd_mux = sys_setup;
			`SCT_OFS_IRQ_ENABLE: rd_mux = {24'h00_0000, irq_enable};
			`SCT_OFS_IRQ_STATUS: rd_mux = {24'h00_0000, irq_status};
			`SCT_OFS_PAD_SETUP: rd_mux = pad_setup_reg;
			`SCT_OFS_PAD_OUTPUT: rd_mux = pad_output_reg;
			`SCT_OFS_OVERTEMP: rd_mux = overtemp_threshold_reg;
			`SCT_OFS_DISTURB: rd_mux = disturbance_ctrl_reg;
			`SCT_OFS_WAKE_CONFIG: rd_mux = wake_cfg;
			default: begin
				for (int i = 0; i < 3; i++) begin
					if (!(i == 2 && AUTH_ACTIVE)) begin
						if (CMD.addr == `SCT_OFS_TIMER_RELOAD + 8'(i)) begin
							rd_mux = {12'h000, t_reload[i]};
						end
						if (CMD.addr == `SCT_OFS_TIMER_CONFIG + 8'(i)) begin
							rd_mux = {25'h000_0000, t_cfg[i]};
						end
						if (CMD.addr == `SCT_OFS_TIMER_VALUE + 8'(i)) begin
							rd_mux = {12'h000, t_value[i]};
						end
					end
				end
			end
		endcase
		case (CMD.code)
			`SCT_CMD_WRITE_OR: wval = rd_mux | CMD.data;
			`SCT_CMD_WRITE_AND: wval = rd_mux & CMD.data;
			default: wval = CMD.data;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			RD_DATA <= 32'h0000_0000;
			RD_VALID <= 1'b0;
		end else begin
			RD_VALID <= cmd_rd;
			RD_DATA <= cmd_rd ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sys_setup <= `SCT_SYSTEM_SETUP_RST;
			irq_enable <= `SCT_IRQ_ENABLE_RST;
			disturbance_ctrl_reg <= 32'h0000_0000;
			wake_cfg <= 32'h0000_0000;
			soft_rst <= 1'b0;
		end else if (wipe) begin
			sys_setup <= `SCT_SYSTEM_SETUP_RST;
			irq_enable <= `SCT_IRQ_ENABLE_RST;
			disturbance_ctrl_reg <= 32'h0000_0000;
			wake_cfg <= 32'h0000_0000;
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= cmd_wr && CMD.addr == `SCT_OFS_SYSTEM_SETUP &&
				wval[`SCT_BIT_SOFT_RESET];
			if (cmd_wr) begin
				case (CMD.addr)
					`SCT_OFS_SYSTEM_SETUP: sys_setup <= wval;
					`SCT_OFS_IRQ_ENABLE: irq_enable <= wval[7:0];
					`SCT_OFS_DISTURB: disturbance_ctrl_reg <= wval;
					`SCT_OFS_WAKE_CONFIG: wake_cfg <= wval;
					default: ;
				endcase
			end
			if (overtemp_event) begin
				sys_setup[`SCT_BIT_RF_ENABLE] <= 1'b0;
			end
		end
	end

	// retained registers: only a hard or soft reset clears them
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pad_setup_reg <= 32'h0000_0000;
			pad_output_reg <= 32'h0000_0000;
			overtemp_threshold_reg <= 32'h0000_0000;
		end else if (soft_rst) begin
			pad_setup_reg <= 32'h0000_0000;
			pad_output_reg <= 32'h0000_0000;
			overtemp_threshold_reg <= 32'h0000_0000;
		end else if (cmd_wr) begin
			if (CMD.addr == `SCT_OFS_PAD_SETUP) pad_setup_reg <= wval;
			if (CMD.addr == `SCT_OFS_PAD_OUTPUT) pad_output_reg <= wval;
			if (CMD.addr == `SCT_OFS_OVERTEMP) overtemp_threshold_reg <= wval;
		end
	end
	assign PAD_SETUP = pad_setup_reg;
	assign PAD_OUT = pad_output_reg;
	assign CARD_MODE = sys_setup[`SCT_BIT_CARD_MODE];

	// ****************************************
	// over-temperature
	// ****************************************
	logic over_lvl, over_prev;
	assign over_lvl = temp_above[overtemp_threshold_reg[1:0]];
	assign overtemp_event = over_lvl && !over_prev;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			over_prev <= 1'b0;
			RF_ON <= 1'b0;
		end else begin
			over_prev <= over_lvl;
			RF_ON <= sys_setup[`SCT_BIT_RF_ENABLE] && !over_lvl && !overtemp_event;
		end
	end

	// ****************************************
	// tick generation
	// ****************************************
	logic [16:0] sys_acc;
	logic sys_tick;
	logic [7:0] pre_div;
	logic rf_prev;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sys_acc <= 17'h0_0000;
			sys_tick <= 1'b0;
			pre_div <= 8'h00;
			rf_prev <= 1'b0;
		end else begin
			rf_prev <= rf_field;
			if (sys_acc + SYS_STEP >= SYS_MOD) begin
				sys_acc <= sys_acc + SYS_STEP - SYS_MOD;
				sys_tick <= 1'b1;
			end else begin
				sys_acc <= sys_acc + SYS_STEP;
				sys_tick <= 1'b0;
			end
			if (sys_tick) begin
				pre_div <= pre_div + 8'h01;
			end
		end
	end

	// ****************************************
	// timers
	// ****************************************
	for (genvar g = 0; g < 3; g++) begin : g_timer
		logic armed, running, start_ev, tick, host_ok;
		logic [7:0] pmask;
		assign host_ok = cmd_wr && !(g == 2 && AUTH_ACTIVE);
		assign pmask = 8'hff >> (3'd7 - t_cfg[g].prescale);
		assign tick = sys_tick && ((pre_div & pmask) == pmask);
		always_comb begin
			case (t_cfg[g].start_sel)
				SEL_NOW: start_ev = 1'b1;
				SEL_RF_ON: start_ev = rf_field && !rf_prev;
				SEL_RF_OFF: start_ev = !rf_field && rf_prev;
				SEL_RX_START: start_ev = RX_START;
				SEL_RX_END: start_ev = RX_END;
				SEL_TX_START: start_ev = TX_START;
				SEL_TX_END: start_ev = TX_END;
				default: start_ev = 1'b0;
			endcase
		end
		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				t_value[g] <= 20'h0_0000;
				t_reload[g] <= 20'h0_0000;
				t_cfg[g] <= '0;
				armed <= 1'b0;
				running <= 1'b0;
				t_expire[g] <= 1'b0;
			end else if (wipe) begin
				t_value[g] <= 20'h0_0000;
				t_reload[g] <= 20'h0_0000;
				t_cfg[g] <= '0;
				armed <= 1'b0;
				running <= 1'b0;
				t_expire[g] <= 1'b0;
			end else begin
				t_expire[g] <= 1'b0;
				if (host_ok && CMD.addr == `SCT_OFS_TIMER_RELOAD + 8'(g)) begin
					t_reload[g] <= wval[19:0];
				end
				if (host_ok && CMD.addr == `SCT_OFS_TIMER_CONFIG + 8'(g)) begin
					t_cfg[g] <= wval[6:0];
					armed <= 1'b1;
					running <= 1'b0;
				end else if (armed && start_ev) begin
					armed <= 1'b0;
					running <= 1'b1;
					t_value[g] <= t_reload[g];
				end else if (g == 1 && EMD_EVENT && disturbance_ctrl_reg[`SCT_BIT_DISTURB_ON]) begin
					running <= 1'b1;
					t_value[g] <= t_reload[g];
				end else if (running && tick) begin
					if (t_value[g] <= 20'h0_0001) begin
						t_expire[g] <= 1'b1;
						if (t_cfg[g].reload_en) begin
							t_value[g] <= t_reload[g];
						end else begin
							t_value[g] <= 20'h0_0000;
							running <= 1'b0;
						end
					end else begin
						t_value[g] <= t_value[g] - 20'h0_0001;
					end
				end
			end
		end
	end

	// ****************************************
	// interrupt flags and pin
	// ****************************************
	always_comb begin
		irq_set = {HV_FAULT, GENERAL_ERROR, CARD_DETECT, overtemp_event, t_expire, startup_done};
		irq_clr = 8'h00;
		if (cmd_wr && CMD.addr == `SCT_OFS_IRQ_CLEAR && !CLEAR_ON_READ) begin
			irq_clr = wval[7:0];
		end
		if (cmd_rd && CMD.addr == `SCT_OFS_IRQ_STATUS && CLEAR_ON_READ) begin
			irq_clr = irq_status;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= 8'h00;
			IRQ_O <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			irq_status <= ((wipe ? 8'h00 : irq_status) & ~irq_clr) | irq_set;
			IRQ_O <= IRQ_ACTIVE_HIGH ~^
				(|(irq_status & (irq_enable | `SCT_NONMASK)));
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	sequence s_overtemp;
		overtemp_event;
	endsequence

	sequence s_standby_cmd;
		cmd_standby;
	endsequence

	irq_pin_level_a: assert property (
		##1 IRQ_O == ($past(IRQ_ACTIVE_HIGH) ~^
		(|($past(irq_status) & ($past(irq_enable) | `SCT_NONMASK)))))
		else $error("interrupt pin level disagrees with flags");
	overtemp_flag_a: assert property (
		s_overtemp |=> irq_status[`SCT_IRQ_OVERTEMP] && !RF_ON)
		else $error("over-temperature did not set flag and drop RF");
	standby_entry_a: assert property (
		s_standby_cmd |=> STANDBY && state == ST_STANDBY)
		else $error("standby not entered after standby command");
	startup_done_a: assert property (
		$rose(state == ST_RUN) |-> startup_done ##1 irq_status[`SCT_IRQ_IDLE])
		else $error("start-up end did not raise idle flag");
	soft_reset_a: assert property (
		soft_rst |=> state == ST_STARTUP && sys_setup == `SCT_SYSTEM_SETUP_RST && !LOW_POWER)
		else $error("soft reset did not restore defaults");
	retain_pads_a: assert property (
		(wake && !soft_rst) |=> $stable(pad_output_reg) && $stable(pad_setup_reg))
		else $error("pad registers lost on wake");
	set_wins_a: assert property (
		(irq_set != 8'h00) |=> (irq_status & $past(irq_set)) == $past(irq_set))
		else $error("event flag lost");
	host_gate_a: assert property (
		(state == ST_STANDBY && CMD_VALID) |=> state == ST_STARTUP ##1 !READY)
		else $error("host activity did not wake device");
	disturb_restart_a: assert property (
		(EMD_EVENT && disturbance_ctrl_reg[0] && !wipe && !g_timer[1].armed &&
		!(cmd_wr && CMD.addr == `SCT_OFS_TIMER_CONFIG + 8'h01)) |=> g_timer[1].running)
		else $error("second timer not restarted on disturbance");
endmodule : sct_top

// *** sct_host.sv ***
`timescale 1ns/1ns
module sct_host (
	input wire logic clk,
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	output logic rst_n,
	output logic cmd_valid,
	output sct_pkg::sct_cmd_t cmd
);
	import sct_pkg::*;

	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// hold the reset pin low for the whole count before release
	task automatic hard_reset(input int cyc);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (cyc) @(negedge clk);
		rst_n = 1'b1;
	endtask : hard_reset

	// one command word; read data is taken in the answer cycle
	task automatic send(input logic [7:0] code, input logic [7:0] addr, input logic [31:0] data,
		output logic [31:0] rdv);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd = {code, addr, data};
		@(negedge clk);
		rdv = rd_valid ? rd_data : 'x;
		cmd_valid = 1'b0;
		// released lines carry garbage so a stale word is never mistaken for a command
		cmd = ~cmd;
	endtask : send
endmodule : sct_host

// *** system_control_timers_irq_test.sv ***
`timescale 1ns/1ns
`include "sct_params.svh"
module system_control_timers_irq_test;
	import sct_pkg::*;
	logic clk = 1'b0;
	logic rst_n, cmd_valid, rd_valid;
	sct_cmd_t cmd;
	logic [31:0] rd_data, pad_setup, pad_out, rd;
	logic rf_field = 1'b0;
	logic [3:0] temp_above = 4'h0;
	logic rf_level = 1'b0;
	logic pvdd_lost = 1'b0;
	logic emd = 1'b0;
	logic [3:0] ev = 4'h0;
	logic auth = 1'b0;
	logic [2:0] nm = 3'h0;
	logic clr_on_read = 1'b0;
	logic irq_high = 1'b1;
	logic irq_o, irq_oe, pull_dn, hiz, iso, low_pw, ready, standby, rf_on, card_mode;
	int num_errors = 0;
	int checks = 0;

	always #5 clk = ~clk;

	sct_top #(.STARTUP_CYC(4)) sct_top_i (.CLK(clk), .RESET_N(rst_n), .CMD_VALID(cmd_valid),
		.CMD(cmd), .RD_DATA(rd_data), .RD_VALID(rd_valid), .RF_FIELD(rf_field),
		.TEMP_ABOVE(temp_above), .RF_LEVEL_DET(rf_level), .PVDD_LOST(pvdd_lost), .RX_START(ev[0]),
		.RX_END(ev[1]), .TX_START(ev[2]), .TX_END(ev[3]), .EMD_EVENT(emd), .AUTH_ACTIVE(auth),
		.CARD_DETECT(nm[0]), .GENERAL_ERROR(nm[1]), .HV_FAULT(nm[2]),
		.CLEAR_ON_READ(clr_on_read), .IRQ_ACTIVE_HIGH(irq_high), .IRQ_O(irq_o), .IRQ_OE(irq_oe),
		.PULL_DOWN_EN(pull_dn), .OUT_HIZ(hiz), .INPUT_ISOLATE(iso), .LOW_POWER(low_pw),
		.READY(ready), .STANDBY(standby), .RF_ON(rf_on), .CARD_MODE(card_mode),
		.PAD_SETUP(pad_setup), .PAD_OUT(pad_out));

	sct_host sct_host_i (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .rst_n(rst_n),
		.cmd_valid(cmd_valid), .cmd(cmd));

	// ****************
	// helpers
	// ****************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	function automatic logic lvl(input logic on);
		return on ? irq_high : ~irq_high;
	endfunction : lvl

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sct_host_i.send(`SCT_CMD_WRITE, a, d, rd);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		sct_host_i.send(`SCT_CMD_READ, a, 32'h0, rd);
	endtask : rdr

	task automatic wait_ready;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk_bit(ready, 1'b1);
	endtask : wait_ready

	task automatic poll_exp(input int lim);
		int n;
		n = 0;
		rd = '0;
		while (rd[1] !== 1'b1 && n < lim) begin
			rdr(`SCT_OFS_IRQ_STATUS);
			n += 2;
		end
		chk_bit(rd[1], 1'b1);
	endtask : poll_exp

	// ****************
	// scenarios
	// ****************
	task automatic t_hard_reset;
		wr(`SCT_OFS_IRQ_ENABLE, 32'h1f);
		fork
			sct_host_i.hard_reset(`SCT_HARD_RESET_CYC);
			begin
				repeat (20) @(negedge clk);
				chk_bit(pull_dn & hiz & iso & low_pw, 1'b1);
				chk_bit(irq_oe, 1'b0);
			end
		join
		wait_ready();
		chk_bit(low_pw, 1'b0);
		chk_bit(pull_dn | hiz | iso | ~irq_oe, 1'b0);
		chk_bit(card_mode, 1'b1);
		chk_bit(irq_o, lvl(1'b0));
		rdr(`SCT_OFS_SYSTEM_SETUP);
		chk_word(rd, `SCT_SYSTEM_SETUP_RST);
		rdr(`SCT_OFS_IRQ_ENABLE);
		chk_word(rd, 32'h0);
		rdr(`SCT_OFS_IRQ_STATUS);
		chk_bit(rd[`SCT_IRQ_IDLE], 1'b1);
		rdr(8'h7f);
		chk_word(rd, 32'h0);
	endtask : t_hard_reset

	task automatic t_soft_reset;
		wr(`SCT_OFS_IRQ_ENABLE, 32'h01);
		@(negedge clk);
		chk_bit(irq_o, lvl(1'b1));
		wr(`SCT_OFS_SYSTEM_SETUP, 32'h0000_0100);
		repeat (2) @(negedge clk);
		chk_bit(low_pw, 1'b0);
		wait_ready();
		rdr(`SCT_OFS_IRQ_ENABLE);
		chk_word(rd, 32'h0);
	endtask : t_soft_reset

	task automatic t_overtemp;
		for (int s = 0; s < 4; s++) begin
			wr(`SCT_OFS_OVERTEMP, 32'(s));
			wr(`SCT_OFS_SYSTEM_SETUP, 32'h3);
			temp_above = 4'((1 << s) - 1);
			repeat (8) @(negedge clk);
			chk_bit(rf_on, 1'b1);
			temp_above = 4'((2 << s) - 1);
			repeat (8) @(negedge clk);
			chk_bit(rf_on, 1'b0);
			rdr(`SCT_OFS_IRQ_STATUS);
			chk_bit(rd[`SCT_IRQ_OVERTEMP], 1'b1);
			chk_bit(irq_o, lvl(1'b0));
			wr(`SCT_OFS_IRQ_ENABLE, 32'h10);
			@(negedge clk);
			chk_bit(irq_o, lvl(1'b1));
			temp_above = 4'h0;
			repeat (8) @(negedge clk);
			wr(`SCT_OFS_IRQ_CLEAR, 32'h10);
			@(negedge clk);
			chk_bit(irq_o, lvl(1'b0));
			wr(`SCT_OFS_IRQ_ENABLE, 32'h0);
		end
		// cooled sensor must let the field come back at the lowest trip point
		wr(`SCT_OFS_OVERTEMP, 32'h0);
		wr(`SCT_OFS_SYSTEM_SETUP, 32'h3);
		repeat (8) @(negedge clk);
		chk_bit(rf_on, 1'b1);
	endtask : t_overtemp

	task automatic t_nonmask;
		for (int i = 0; i < 3; i++) begin
			irq_high = i[0];
			@(negedge clk);
			nm[i] = 1'b1;
			@(negedge clk);
			nm[i] = 1'b0;
			@(negedge clk);
			chk_bit(irq_o, lvl(1'b1));
			rdr(`SCT_OFS_IRQ_STATUS);
			chk_bit(rd[5 + i], 1'b1);
			wr(`SCT_OFS_IRQ_CLEAR, 32'(1 << (5 + i)));
			@(negedge clk);
			chk_bit(irq_o, lvl(1'b0));
		end
		irq_high = 1'b1;
		clr_on_read = 1'b1;
		@(negedge clk);
		nm[1] = 1'b1;
		@(negedge clk);
		nm[1] = 1'b0;
		rdr(`SCT_OFS_IRQ_STATUS);
		chk_bit(rd[`SCT_IRQ_GEN_ERR], 1'b1);
		rdr(`SCT_OFS_IRQ_STATUS);
		chk_bit(rd[`SCT_IRQ_GEN_ERR], 1'b0);
		chk_bit(irq_o, lvl(1'b0));
		clr_on_read = 1'b0;
	endtask : t_nonmask

	task automatic t_auth;
		auth = 1'b1;
		wr(8'h12, 32'h7);
		rdr(8'h12);
		chk_word(rd, 32'h0);
		auth = 1'b0;
		rdr(8'h12);
		chk_word(rd, 32'h0);
		wr(8'h12, 32'h7);
		rdr(8'h12);
		chk_word(rd, 32'h7);
	endtask : t_auth

	task automatic t_timer;
		wr(`SCT_OFS_TIMER_RELOAD, 32'hffff_ffff);
		rdr(`SCT_OFS_TIMER_RELOAD);
		chk_word(rd, 32'h000f_ffff);
		wr(`SCT_OFS_TIMER_RELOAD, 32'h1);
		for (int k = 0; k < 8; k++) begin
			wr(`SCT_OFS_IRQ_CLEAR, 32'h2);
			wr(`SCT_OFS_TIMER_CONFIG, 32'(k));
			poll_exp(45 * (1 << k) + 40);
		end
		for (int s = 1; s < 7; s++) begin
			wr(`SCT_OFS_IRQ_CLEAR, 32'h2);
			wr(`SCT_OFS_TIMER_CONFIG, 32'(s << 3));
			repeat (60) @(negedge clk);
			rdr(`SCT_OFS_IRQ_STATUS);
			chk_bit(rd[1], 1'b0);
			if (s < 3) begin
				rf_field = (s == 1);
			end else begin
				ev[s - 3] = 1'b1;
				@(negedge clk);
				ev = 4'h0;
			end
			poll_exp(80);
		end
	endtask : t_timer

	// timer one runs mid-count when a disturbance pulse restarts it
	task automatic t_disturb;
		wr(`SCT_OFS_DISTURB, 32'h1);
		wr(`SCT_OFS_TIMER_RELOAD + 8'h01, 32'h6);
		wr(`SCT_OFS_IRQ_CLEAR, 32'h4);
		wr(`SCT_OFS_TIMER_CONFIG + 8'h01, 32'h0);
		repeat (45) @(negedge clk);
		emd = 1'b1;
		@(negedge clk);
		emd = 1'b0;
		repeat (52) @(negedge clk);
		rdr(`SCT_OFS_IRQ_STATUS);
		chk_bit(rd[2], 1'b0);
		repeat (45) @(negedge clk);
		rdr(`SCT_OFS_IRQ_STATUS);
		chk_bit(rd[2], 1'b1);
	endtask : t_disturb

	// how: 0 host access, 1 timer expiry, 2 RF level, 3 host supply loss
	task automatic t_standby(input int how);
		wr(`SCT_OFS_PAD_SETUP, 32'h5a);
		wr(`SCT_OFS_PAD_OUTPUT, 32'ha5);
		wr(`SCT_OFS_OVERTEMP, 32'h2);
		wr(`SCT_OFS_IRQ_ENABLE, 32'h02);
		wr(`SCT_OFS_WAKE_CONFIG, 32'(how == 0 ? 0 : 1 << (how - 1)));
		wr(`SCT_OFS_TIMER_RELOAD, 32'd20);
		wr(`SCT_OFS_TIMER_CONFIG, 32'h0);
		sct_host_i.send(`SCT_CMD_SWITCH_MODE, 8'h0, `SCT_MODE_STANDBY, rd);
		repeat (20) @(negedge clk);
		chk_bit(standby, 1'b1);
		chk_word(pad_out, 32'ha5);
		if (how == 0) begin
			wr(8'h7f, 32'h0);
		end else if (how > 1) begin
			{pvdd_lost, rf_level} = 2'(how - 1);
			repeat (6) @(negedge clk);
			{pvdd_lost, rf_level} = 2'b00;
		end
		wait_ready();
		chk_bit(standby, 1'b0);
		chk_word(pad_out, 32'ha5);
		rdr(`SCT_OFS_PAD_SETUP);
		chk_word(rd, 32'h5a);
		rdr(`SCT_OFS_OVERTEMP);
		chk_word(rd, 32'h2);
		rdr(`SCT_OFS_IRQ_ENABLE);
		chk_word(rd, 32'h0);
		rdr(`SCT_OFS_IRQ_STATUS);
		chk_bit(rd[`SCT_IRQ_IDLE], 1'b1);
	endtask : t_standby

	task automatic finish_test;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		sct_host_i.hard_reset(20);
		wait_ready();
		t_hard_reset();
		t_soft_reset();
		t_overtemp();
		t_nonmask();
		t_auth();
		t_timer();
		t_disturb();
		for (int h = 0; h < 4; h++) begin
			t_standby(h);
		end
		finish_test();
	end
endmodule : system_control_timers_irq_test
